// >>> logic/gpio_params.svh
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH
// How it works
// - Every bidirectional port bit has its own direction bit.
// - Reset clears every direction bit, so all ports start as inputs.
// - Port zero drives both levels; port one is open-drain, low only.
// - Ports zero, one, two and seven pull up only on input bits.
// - Ports three, five and six pull up in input and output modes.
// - Port two acts as port zero plus optional key wake.
// - In power-down, an enabled low key-wake pin raises the wake request.
// - Port seven acts as port two: push-pull, key wake, input-only pull-up.
// - Port six is open-drain; its pull-up acts in both modes.
// - Serial enable hands port three bits seven to four to serial I/O.
// - Port three low bits carry timer output, interrupt two, sub-clock.
// - Port four is input only; low nibble shared with analog inputs.
// - Port five carries interrupt three, timer inputs, trigger, pulse outputs.
// - Data register at even address, direction next; port zero 00e0.
// - Port one at 00e2/00e3, port two at 00e4/00e5.
// - Port three at 00e8/00e9, port five at 00ec/00ed.
// - Port six 00d0/00d1, port seven 00d2/00d3, port four 00f5.
// - Key-wake enables sit at 00ee for port two, 00d5 for seven.
`define ADR_P6_DATA 8'hd0
`define ADR_P6_DIR  8'hd1
`define ADR_P7_DATA 8'hd2
`define ADR_P7_DIR  8'hd3
`define ADR_P7_WAKE 8'hd5
`define ADR_P0_DATA 8'he0
`define ADR_P0_DIR  8'he1
`define ADR_P1_DATA 8'he2
`define ADR_P1_DIR  8'he3
`define ADR_P2_DATA 8'he4
`define ADR_P2_DIR  8'he5
`define ADR_P3_DATA 8'he8
`define ADR_P3_DIR  8'he9
`define ADR_P5_DATA 8'hec
`define ADR_P5_DIR  8'hed
`define ADR_P2_WAKE 8'hee
`define ADR_P4_IN   8'hf5
`define RESET_BYTE  8'h00
`define RESET_MIN_NS 16000
`endif

// >>> logic/gpio_pkg.sv
package gpio_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] dir;
	} port_regs_t;
	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
		logic [7:0] pu;
	} pin_drive_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} cpu_req_t;
endpackage

// >>> logic/pin_sync.sv
`default_nettype none
module pin_sync
	import gpio_pkg::*;
#(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	// Pins in, synchronised out
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_state_t;
	sync_state_t st, next_st;
	always_comb begin
		next_st.s1 = pin_in;
		next_st.s2 = st.s1;
	end
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign pin_sync_out = st.s2;
endmodule
`default_nettype wire

// >>> logic/port_cell.sv
`default_nettype none
`include "gpio_params.svh"
module port_cell
	import gpio_pkg::*;
#(
	parameter bit OPEN_DRAIN = 1'b0,
	parameter bit PU_ALWAYS  = 1'b0
) (
	// Register content and pins
	input  wire logic [7:0] data,
	input  wire logic [7:0] dir,
	input  wire logic [7:0] pin_level,
	input  wire logic [7:0] pu_option,
	// Pad control and read-back
	output pin_drive_t      drive,
	output logic      [7:0] read_value
);
	always_comb begin
		// Open-drain drives only low bits; a high is a released pin
		drive.o = OPEN_DRAIN ? 8'h00 : data;
		drive.oe = OPEN_DRAIN ? (dir & ~data) : dir;
		drive.pu = PU_ALWAYS ? pu_option : (pu_option & ~dir);
		read_value = (dir & data) | (~dir & pin_level);
	end
endmodule
`default_nettype wire

// >>> logic/gpio_block.sv
`default_nettype none
`include "gpio_params.svh"
module gpio_block
	import gpio_pkg::*;
#(
	parameter bit         KEY_WAKE_OPTION = 1'b1,
	parameter logic [7:0] PU_OPT0 = 8'h00,
	parameter logic [7:0] PU_OPT1 = 8'h00,
	parameter logic [7:0] PU_OPT2 = 8'h00,
	parameter logic [7:0] PU_OPT3 = 8'h00,
	parameter logic [7:0] PU_OPT4 = 8'h00,
	parameter logic [7:0] PU_OPT5 = 8'h00,
	parameter logic [7:0] PU_OPT6 = 8'h00,
	parameter logic [7:0] PU_OPT7 = 8'h00
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	// CPU special function area
	input  wire cpu_req_t    cpu,
	output logic       [7:0] rdata,
	// Pins, port zero to seven, port four input only
	input  wire logic [63:0] pin_in,
	output pin_drive_t       pad0,
	output pin_drive_t       pad1,
	output pin_drive_t       pad2,
	output pin_drive_t       pad3,
	output logic       [7:0] pad4_pu,
	output pin_drive_t       pad5,
	output pin_drive_t       pad6,
	output pin_drive_t       pad7,
	// Shared functions on port three
	input  wire logic        serial_enable,
	input  wire logic        serial_ready_out,
	input  wire logic        serial_clock_out,
	input  wire logic        serial_clock_drive,
	input  wire logic        serial_data_out,
	input  wire logic        timer4_half_enable,
	input  wire logic        timer4_half,
	input  wire logic        sub_clock_enable,
	output logic             serial_clock_in,
	output logic             serial_data_in,
	output logic             second_external_interrupt,
	output logic             sub_clock_in,
	// Shared functions on ports four and five
	output logic       [3:0] analog_inputs_four_to_seven,
	output logic             third_external_interrupt,
	output logic             timer3_input,
	output logic             timer5_input,
	output logic             converter_trigger,
	input  wire logic  [3:0] pulse_width_enable,
	input  wire logic  [3:0] pulse_width_outputs,
	// Power-down and wake
	input  wire logic        power_down,
	output logic             key_wake_request
);
	typedef struct packed {
		port_regs_t [7:0] p;
		logic [7:0]       wake2;
		logic [7:0]       wake7;
		logic [7:0]       rdata;
		pin_drive_t [7:0] pad;
		logic [7:0]       pad4_pu;
		logic [11:0]      alt;
		logic             wake;
	} blk_state_t;

	blk_state_t st, next_st;
	logic [63:0] pins;
	pin_drive_t [7:0] cell_drive;
	logic [7:0][7:0] cell_read;

	pin_sync #(.W(64)) u_sync (
		.ref_clk      (ref_clk),
		.rst_b        (rst_b),
		.pin_in       (pin_in),
		.pin_sync_out (pins)
	);

	localparam bit [7:0] OD_MAP = 8'b0110_1010;
	localparam bit [7:0] PA_MAP = 8'b0110_1000;
	localparam logic [7:0][7:0] PU_OPTS = {PU_OPT7, PU_OPT6, PU_OPT5, PU_OPT4,
		PU_OPT3, PU_OPT2, PU_OPT1, PU_OPT0};

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_port
			port_cell #(.OPEN_DRAIN(OD_MAP[g]), .PU_ALWAYS(PA_MAP[g])) u_cell (
				.data       (st.p[g].data),
				.dir        (st.p[g].dir),
				.pin_level  (pins[8*g +: 8]),
				.pu_option  (PU_OPTS[g]),
				.drive      (cell_drive[g]),
				.read_value (cell_read[g])
			);
		end
	endgenerate

	// Port index of a data or direction address, 4'hf when none
	function automatic logic [3:0] port_of(input logic [7:0] a);
		unique case ({a[7:1], 1'b0})
			`ADR_P0_DATA: port_of = 4'h0;
			`ADR_P1_DATA: port_of = 4'h1;
			`ADR_P2_DATA: port_of = 4'h2;
			`ADR_P3_DATA: port_of = 4'h3;
			`ADR_P5_DATA: port_of = 4'h5;
			`ADR_P6_DATA: port_of = 4'h6;
			`ADR_P7_DATA: port_of = 4'h7;
			default:      port_of = 4'hf;
		endcase
	endfunction

	logic [3:0] idx;
	always_comb begin
		next_st = st;
		idx = port_of(cpu.addr);
		if (cpu.wr) begin
			if (idx != 4'hf && !cpu.addr[0])
				next_st.p[idx[2:0]].data = cpu.wdata;
			if (idx != 4'hf && cpu.addr[0])
				next_st.p[idx[2:0]].dir = cpu.wdata;
			if (cpu.addr == `ADR_P2_WAKE)
				next_st.wake2 = cpu.wdata;
			if (cpu.addr == `ADR_P7_WAKE)
				next_st.wake7 = cpu.wdata;
		end
		// Unmapped reads return zero
		next_st.rdata = 8'h00;
		if (cpu.rd) begin
			if (idx != 4'hf)
				next_st.rdata = cpu.addr[0] ? st.p[idx[2:0]].dir : cell_read[idx[2:0]];
			else if (cpu.addr == `ADR_P4_IN)
				next_st.rdata = pins[39:32];
			else if (cpu.addr == `ADR_P2_WAKE)
				next_st.rdata = st.wake2;
			else if (cpu.addr == `ADR_P7_WAKE)
				next_st.rdata = st.wake7;
		end
		for (int i = 0; i < 8; i++)
			next_st.pad[i] = cell_drive[i];
		next_st.pad[4] = '0;
		next_st.pad4_pu = PU_OPT4;
		// Port three takeover: serial on high nibble, timer and sub-clock below
		if (serial_enable) begin
			next_st.pad[3].o[7] = 1'b0;
			next_st.pad[3].oe[7] = ~serial_ready_out;
			next_st.pad[3].o[6] = 1'b0;
			next_st.pad[3].oe[6] = serial_clock_drive & ~serial_clock_out;
			next_st.pad[3].o[5] = 1'b0;
			next_st.pad[3].oe[5] = ~serial_data_out;
			next_st.pad[3].oe[4] = 1'b0;
		end
		if (timer4_half_enable) begin
			next_st.pad[3].o[3] = 1'b0;
			next_st.pad[3].oe[3] = ~timer4_half;
		end
		if (sub_clock_enable) begin
			next_st.pad[3].oe[1:0] = 2'b00;
		end
		for (int b = 0; b < 4; b++) begin
			if (pulse_width_enable[b]) begin
				next_st.pad[5].o[4+b] = 1'b0;
				next_st.pad[5].oe[4+b] = ~pulse_width_outputs[b];
			end
		end
		// Serial clock 3.6, interrupt two 3.2, serial data 3.4, sub-clock 3.1
		next_st.alt = {pins[30], pins[26], pins[28], pins[25],
			pins[35:32], pins[40], pins[41], pins[42], pins[43]};
		// Key wake: OR of enabled pins low, only while powered down
		next_st.wake = KEY_WAKE_OPTION && power_down &&
			(|(st.wake2 & ~pins[23:16]) || |(st.wake7 & ~pins[63:56]));
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0; // Direction zero means input, drivers off
		end else begin
			st <= next_st;
		end
	end

	assign rdata = st.rdata;
	assign pad0 = st.pad[0];
	assign pad1 = st.pad[1];
	assign pad2 = st.pad[2];
	assign pad3 = st.pad[3];
	assign pad4_pu = st.pad4_pu;
	assign pad5 = st.pad[5];
	assign pad6 = st.pad[6];
	assign pad7 = st.pad[7];
	assign key_wake_request = st.wake;
	assign serial_clock_in = st.alt[11];
	assign second_external_interrupt = st.alt[10];
	assign serial_data_in = st.alt[9];
	assign sub_clock_in = st.alt[8];
	assign analog_inputs_four_to_seven = st.alt[7:4];
	assign third_external_interrupt = st.alt[3];
	assign timer3_input = st.alt[2];
	assign timer5_input = st.alt[1];
	assign converter_trigger = st.alt[0];

	a_reset_inputs: assert property (@(posedge ref_clk) $rose(rst_b) |->
		pad0.oe == 8'h00 && pad7.oe == 8'h00)
		else $error("ports not inputs after reset");
	a_open_drain_one: assert property (@(posedge ref_clk) disable iff (!rst_b)
		pad1.o == 8'h00 && pad1.oe == ($past(st.p[1].dir) & ~$past(st.p[1].data)))
		else $error("port one drives high");
	a_push_pull_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
		pad0.oe == $past(st.p[0].dir) && pad0.o == $past(st.p[0].data))
		else $error("port zero enable not direction");
	a_push_pull_two: assert property (@(posedge ref_clk) disable iff (!rst_b)
		pad2.oe == $past(st.p[2].dir) && pad2.o == $past(st.p[2].data))
		else $error("port two not push-pull");
	a_push_pull_seven: assert property (@(posedge ref_clk) disable iff (!rst_b)
		pad7.oe == $past(st.p[7].dir) && pad7.o == $past(st.p[7].data))
		else $error("port seven not push-pull");
	a_open_drain_six: assert property (@(posedge ref_clk) disable iff (!rst_b)
		pad6.o == 8'h00 && pad6.oe == ($past(st.p[6].dir) & ~$past(st.p[6].data)))
		else $error("port six drives high");
	a_pull_zero_input: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$past(rst_b) |-> pad0.pu == (PU_OPT0 & ~$past(st.p[0].dir)))
		else $error("port zero pull-up wrong");
	a_pull_three_both: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$past(rst_b) |-> pad3.pu == PU_OPT3) else $error("port three pull-up lost");
	a_serial_in_free: assert property (@(posedge ref_clk) disable iff (!rst_b)
		serial_enable |=> pad3.oe[4] == 1'b0) else $error("serial input pin driven");
	a_data_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cpu.wr && cpu.addr == `ADR_P0_DATA |=> st.p[0].data == $past(cpu.wdata))
		else $error("data write lost");
	a_pull_input_only: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(pad7.pu & pad7.oe) == 8'h00) else $error("pull-up on output bit");
	a_pull_six_both: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$past(rst_b) |-> pad6.pu == PU_OPT6) else $error("port six pull-up lost");
	a_wake_gated: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!$past(power_down) |-> !key_wake_request)
		else $error("wake outside power-down");
	a_wake_enable: assert property (@(posedge ref_clk) disable iff (!rst_b)
		($past(st.wake2) == 8'h00 && $past(st.wake7) == 8'h00) |-> !key_wake_request)
		else $error("wake from disabled pin");
	a_dir_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cpu.rd && cpu.addr == `ADR_P0_DIR |=> rdata == $past(st.p[0].dir))
		else $error("direction readback wrong");
	a_p4_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
		cpu.rd && cpu.addr == `ADR_P4_IN |=> rdata == $past(pins[39:32]))
		else $error("port four read wrong");
	c_wake: cover property (@(posedge ref_clk) key_wake_request);
	c_serial: cover property (@(posedge ref_clk) serial_enable && pad3.oe[5]);
	c_write_read: cover property (@(posedge ref_clk) cpu.wr ##1 cpu.rd);
	c_open_low: cover property (@(posedge ref_clk) pad1.oe != 8'h00);
	c_sub_clock: cover property (@(posedge ref_clk) sub_clock_enable && pad3.oe[1:0] == 2'b00);
endmodule
`default_nettype wire

// >>> tb/board_model.sv
`default_nettype none
module board_model
	import gpio_pkg::*;
(
	// Clock
	input  wire logic        ref_clk,
	// Pad drive from the device
	input  wire pin_drive_t [7:0] pads,
	// Keys and sources behind resistors
	input  wire logic [63:0] ext_en,
	input  wire logic [63:0] ext_lvl,
	// Pin levels
	output logic      [63:0] pin_in
);
	logic flt = 1'b0;
	// An undriven pin with no pull-up wanders, so a stale level never passes
	always @(posedge ref_clk) begin
		flt <= ~flt;
	end
	always_comb begin
		for (int i = 0; i < 64; i++) begin
			if (pads[i/8].oe[i%8])
				pin_in[i] = pads[i/8].o[i%8];
			else if (ext_en[i])
				pin_in[i] = ext_lvl[i];
			else if (pads[i/8].pu[i%8])
				pin_in[i] = 1'b1;
			else
				pin_in[i] = flt ^ i[0];
		end
	end
endmodule
`default_nettype wire

// >>> tb/test_multi_port_gpio_with_key_wake.sv
`default_nettype none
module test_multi_port_gpio_with_key_wake
	import gpio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, rst_b, serial_enable, serial_ready_out, serial_clock_out, serial_clock_drive;
	logic serial_data_out, timer4_half_enable, timer4_half, sub_clock_enable, power_down;
	logic serial_clock_in, serial_data_in, second_external_interrupt, sub_clock_in;
	logic third_external_interrupt, timer3_input, timer5_input, converter_trigger;
	logic key_wake_request;
	logic [3:0] analog_inputs_four_to_seven, pulse_width_enable, pulse_width_outputs;
	logic [7:0] rdata, pad4_pu, v, x, w2, w7;
	logic [7:0] dv [8];
	logic [7:0] rv [8];
	logic [7:0] pv [8];
	logic [63:0] pin_in, ext_en, ext_lvl;
	cpu_req_t cpu;
	pin_drive_t pad0, pad1, pad2, pad3, pad5, pad6, pad7, e;
	pin_drive_t [7:0] pads;
	integer seed = 15;
	int n_fail = 0;
	int n_checks = 0;
	localparam logic [7:0] ADR [8] = '{8'he0, 8'he2, 8'he4, 8'he8, 8'h00, 8'hec, 8'hd0, 8'hd2};
	// Pull-up options per port; ports one, two and five have none fitted
	localparam logic [63:0] PU_ALL = 64'hff3c_00c3_5a00_00f0;
	assign pads = {pad7, pad6, pad5, pin_drive_t'{8'h00, 8'h00, pad4_pu}, pad3, pad2, pad1, pad0};
	gpio_block #(.PU_OPT0(PU_ALL[7:0]), .PU_OPT3(PU_ALL[31:24]), .PU_OPT4(PU_ALL[39:32]),
		.PU_OPT6(PU_ALL[55:48]), .PU_OPT7(PU_ALL[63:56])) gpio_block_inst (.*);
	board_model board_model_inst (.*);
	function automatic logic [7:0] rnd();
		return 8'($random(seed));
	endfunction
	function automatic pin_drive_t exp_pad(int k, logic [7:0] d, logic [7:0] r);
		logic [7:0] pu;
		pu = PU_ALL[8*k +: 8];
		if (!(k == 3 || k == 5 || k == 6))
			pu = pu & ~r;
		if (k == 1 || k == 3 || k == 5 || k == 6)
			return '{8'h00, r & ~d, pu};
		return '{d, r, pu};
	endfunction
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cpu <= '{a, d, 1'b1, 1'b0};
		@(posedge ref_clk);
		cpu <= '0;
		@(posedge ref_clk);
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		cpu <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk);
		cpu <= '0;
		#1 q = rdata;
		check(nm, q, exp);
		@(posedge ref_clk);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		#300000;
		n_fail++;
		finish_test();
	end
	initial begin
		{rst_b, serial_enable, serial_ready_out, serial_clock_out, serial_clock_drive} = '0;
		{serial_data_out, timer4_half_enable, timer4_half, sub_clock_enable, power_down} = '0;
		{pulse_width_enable, pulse_width_outputs} = '0;
		cpu = '0;
		ext_en = '1;
		ext_lvl = '1;
		// Far shorter than the real minimum low time; only the edge matters here
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		for (int k = 0; k < 8; k++) begin
			if (k == 4)
				continue;
			check("oe0", pads[k].oe, 8'h00);
			rchk("dir0", ADR[k] + 8'h01, 8'h00);
		end
		for (int i = 0; i < 20; i++) begin
			ext_lvl <= 64'({$random(seed), $random(seed)});
			// A pin with no pull-up fitted always has a source, so it never floats
			ext_en <= 64'({$random(seed), $random(seed)}) | ~PU_ALL;
			for (int k = 0; k < 8; k++) begin
				if (k == 4)
					continue;
				dv[k] = rnd();
				rv[k] = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : rnd();
				wr(ADR[k] + 8'h01, rv[k]);
				wr(ADR[k], dv[k]);
			end
			repeat (4) @(posedge ref_clk);
			for (int k = 0; k < 8; k++) begin
				if (k == 4)
					continue;
				e = exp_pad(k, dv[k], rv[k]);
				v = ext_en[8*k +: 8];
				pv[k] = (e.oe & e.o) | (~e.oe & v & ext_lvl[8*k +: 8]) | (~e.oe & ~v & e.pu);
				check("oe", pads[k].oe, e.oe);
				check("o", pads[k].o & pads[k].oe, e.o & e.oe);
				check("pu", pads[k].pu, e.pu);
				rchk("data", ADR[k], (rv[k] & dv[k]) | (~rv[k] & pv[k]));
				rchk("dir", ADR[k] + 8'h01, rv[k]);
			end
			pv[4] = (ext_en[39:32] & ext_lvl[39:32]) | (~ext_en[39:32] & PU_ALL[39:32]);
			wr(8'hf5, rnd());
			rchk("p4", 8'hf5, pv[4]);
			rchk("hole", 8'he6, 8'h00);
			check("an", {4'h0, analog_inputs_four_to_seven}, {4'h0, pv[4][3:0]});
			check("pu4", pad4_pu, PU_ALL[39:32]);
			check("alt", {serial_clock_in, serial_data_in, second_external_interrupt,
				sub_clock_in, third_external_interrupt, timer3_input, timer5_input,
				converter_trigger}, {pv[3][6], pv[3][4], pv[3][2], pv[3][1],
				pv[5][0], pv[5][1], pv[5][2], pv[5][3]});
		end
		// Bits one and zero pull low until the sub-clock takes them
		wr(8'he8, 8'h00);
		wr(8'he9, 8'h03);
		wr(8'hed, 8'h00);
		repeat (6) begin
			v = rnd();
			{serial_ready_out, serial_clock_out, serial_data_out, timer4_half} <= v[3:0];
			pulse_width_outputs <= v[7:4];
			{serial_enable, serial_clock_drive, timer4_half_enable} <= 3'b111;
			sub_clock_enable <= v[4];
			pulse_width_enable <= 4'hf;
			repeat (3) @(posedge ref_clk);
			check("ser", pads[3].oe & 8'heb, {~v[3:1], 1'b0, ~v[0], 1'b0, {2{~v[4]}}});
			check("pwm", pads[5].oe & 8'hf0, {~v[7:4], 4'h0});
		end
		{serial_enable, serial_clock_drive, timer4_half_enable, sub_clock_enable} <= '0;
		pulse_width_enable <= '0;
		ext_en <= '1;
		wr(8'he5, 8'h00);
		wr(8'hd3, 8'h00);
		for (int i = 0; i < 24; i++) begin
			w2 = rnd() & rnd();
			w7 = rnd() & rnd();
			v = (i < 2) ? 8'hff : rnd() | rnd();
			x = (i < 2) ? 8'hff : rnd() | rnd();
			wr(8'hee, w2);
			wr(8'hd5, w7);
			ext_lvl <= {x, 32'hffff_ffff, v, 16'hffff};
			power_down <= (i % 3 != 0);
			repeat (5) @(posedge ref_clk);
			check("wake", {7'h0, key_wake_request},
				{7'h0, power_down & |((w2 & ~v) | (w7 & ~x))});
			rchk("kw2", 8'hee, w2);
			rchk("kw7", 8'hd5, w7);
		end
		finish_test();
	end
endmodule
`default_nettype wire
